// ===== design/fixed_point_mac_datapath.sv
// fixed-point ALU, accumulator, scaling shifter, output shifters and 16x16 multiplier
// assumes the sequencer presents opcode, shift counts and bus words on the same clock
// Function
// RL1: most ALU operations complete and write back in a single clock cycle.
// RL2: branch condition comes from ALU status or from one selected word bit.
// RL3: accumulator contents are offered as a jump target address.
// RL4: normalize shifts accumulator left one step while top two bits agree.
// RL5: a selected bit of a data memory word is tested for branching.
// RL6: ALU operand is accumulator plus product path or scaling shifter output.
// RL7: every ALU result is written back into the accumulator.
// RL8: accumulator is stored as separate upper and lower 16-bit halves.
// RL9: store path shifts the value; accumulator itself stays unchanged.
// RL10: scaling shifter takes 16-bit bus word, yields 32-bit ALU operand.
// RL11: scaling shift amount is 0 to 16 bits from the instruction.
// RL12: low bits vacated by the scaling shift become zero.
// RL13: high bits are zero or sign copies according to sign_extend_enable.
// RL14: multiplier forms a signed or unsigned 32-bit product in one cycle.
// RL15: mult_operand_reg holds one multiplier operand until reloaded.
// RL16: mult_result_reg captures and holds every product.
// RL17: multiply takes program-bus and data-bus operands together, one per cycle.
// RL18: product passes a four-mode shifter before reaching the ALU.
// RL19: modes are none, left one, left four, arithmetic right six.
`timescale 1ns/1ps
module fixed_point_mac_datapath
  import mac_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // instruction controls
  input wire logic [3:0] alu_op_in,
  input wire logic alu_src_prod_in,
  input wire logic [SHIFT_W-1:0] scale_shift_in,
  input wire logic sign_extend_enable_in,
  input wire logic [1:0] pshift_mode_in,
  // multiplier controls
  input wire logic operand_load_in,
  input wire logic mult_en_in,
  input wire logic mult_signed_in,
  // buses
  input wire logic [DATA_W-1:0] data_bus_in,
  input wire logic [DATA_W-1:0] prog_bus_in,
  // store and bit test
  input wire logic store_in,
  input wire logic store_upper_in,
  input wire logic [OUT_SHIFT_W-1:0] store_shift_in,
  input wire logic bit_test_in,
  input wire logic [BIT_SEL_W-1:0] bit_sel_in,
  // results
  output logic [ACC_W-1:0] acc_out,
  output logic [ACC_W-1:0] jump_target_out,
  output logic [DATA_W-1:0] store_data_out,
  output logic store_valid_out,
  output logic [ACC_W-1:0] mult_result_out,
  output logic [DATA_W-1:0] mult_operand_out,
  output logic acc_zero_out,
  output logic acc_neg_out,
  output logic carry_out,
  output logic overflow_out,
  output logic bit_test_out,
  output logic norm_done_out
);

  logic [ACC_W-1:0] acc_reg, acc_next;
  logic [DATA_W-1:0] mult_operand_reg;
  logic [ACC_W-1:0] mult_result_reg, mult_result_next;
  logic carry_reg, carry_next, overflow_reg, overflow_next;
  logic [DATA_W-1:0] store_data_reg;
  logic store_valid_reg, bit_test_reg, norm_done_reg, norm_done_next;
  logic acc_zero_reg, acc_neg_reg;

  // scaling shifter: operand extended to 32 bits first, then shifted
  wire logic [ACC_W-1:0] scale_ext;
  wire logic [SHIFT_W-1:0] scale_amt;
  wire logic [ACC_W-1:0] scale_out;
  assign scale_ext = sign_extend_enable_in ? {{DATA_W{data_bus_in[DATA_W-1]}}, data_bus_in} //RL13
                                           : {{DATA_W{1'b0}}, data_bus_in}; //RL10
  // counts above the maximum are clamped rather than wrapping into odd results
  assign scale_amt = (scale_shift_in > SCALE_MAX) ? SCALE_MAX : scale_shift_in; //RL11
  assign scale_out = scale_ext << scale_amt; //RL12

  // product shifter
  function automatic logic [ACC_W-1:0] pshift(input logic [ACC_W-1:0] p, input logic [1:0] m);
    logic [ACC_W-1:0] r;
    r = p;
    case (m)
      PM_L1: r = p << PSHIFT_L1;
      PM_L4: r = p << PSHIFT_L4;
      PM_R6: r = ACC_W'($signed(p) >>> PSHIFT_R6);
      default: r = p;
    endcase
    return r;
  endfunction

  wire logic [ACC_W-1:0] prod_shifted;
  wire logic [ACC_W-1:0] alu_b;
  assign prod_shifted = pshift(mult_result_reg, pshift_mode_in); //RL18 RL19
  assign alu_b = alu_src_prod_in ? prod_shifted : scale_out; //RL6

  // multiplier: both operands taken in the same cycle when loading and multiplying together
  wire logic [DATA_W-1:0] mul_a;
  wire logic [ACC_W:0] prod_s;
  wire logic [ACC_W-1:0] prod_u;
  assign mul_a = operand_load_in ? data_bus_in : mult_operand_reg; //RL17
  assign prod_s = ($signed({mul_a[DATA_W-1], mul_a}) * $signed({prog_bus_in[DATA_W-1], prog_bus_in}));
  assign prod_u = mul_a * prog_bus_in;
  assign mult_result_next = mult_en_in ? (mult_signed_in ? prod_s[ACC_W-1:0] : prod_u) //RL14
                                       : mult_result_reg;

  // arithmetic
  wire logic [ACC_W:0] sum, diff, negv;
  assign sum = {1'b0, acc_reg} + {1'b0, alu_b};
  assign diff = {1'b0, acc_reg} - {1'b0, alu_b};
  assign negv = {(ACC_W+1){1'b0}} - {1'b0, acc_reg};
  wire logic add_ovf, sub_ovf;
  assign add_ovf = (acc_reg[MSB] == alu_b[MSB]) && (sum[MSB] != acc_reg[MSB]);
  assign sub_ovf = (acc_reg[MSB] != alu_b[MSB]) && (diff[MSB] != acc_reg[MSB]);
  // normalize step: one bit per cycle while the two top bits agree and acc is nonzero
  wire logic norm_needed;
  assign norm_needed = (acc_reg[MSB] == acc_reg[NORM_TOP]) && (acc_reg != ACC_RESET); //RL4

  always_comb begin
    acc_next = acc_reg;
    carry_next = carry_reg;
    overflow_next = overflow_reg;
    norm_done_next = 1'b0;
    case (alu_op_t'(alu_op_in))
      OP_ADD: begin
        acc_next = sum[ACC_W-1:0]; //RL7
        carry_next = sum[ACC_W];
        overflow_next = add_ovf;
      end
      OP_SUB: begin
        acc_next = diff[ACC_W-1:0];
        carry_next = ~diff[ACC_W];
        overflow_next = sub_ovf;
      end
      OP_LOAD: acc_next = alu_b;
      OP_AND: acc_next = acc_reg & alu_b; //RL1
      OP_OR: acc_next = acc_reg | alu_b;
      OP_XOR: acc_next = acc_reg ^ alu_b;
      OP_ZERO: acc_next = ACC_RESET;
      OP_NEG: begin
        acc_next = negv[ACC_W-1:0];
        overflow_next = (acc_reg == {1'b1, {(ACC_W-1){1'b0}}});
      end
      OP_NORM: begin
        if (norm_needed) begin
          acc_next = acc_reg << 1; //RL4
        end else begin
          norm_done_next = 1'b1;
        end
      end
      default: acc_next = acc_reg;
    endcase
  end

  // store path: shift in a copy only, the accumulator is not touched
  wire logic [ACC_W+7:0] store_wide;
  wire logic [DATA_W-1:0] store_half;
  assign store_wide = {acc_reg, 8'h00} << store_shift_in; //RL9
  assign store_half = store_upper_in ? store_wide[ACC_W+7:DATA_W+8] : store_wide[DATA_W+7:8]; //RL8
  wire logic bit_sel_val;
  assign bit_sel_val = data_bus_in[(DATA_W-1) - bit_sel_in]; //RL5

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_reg <= ACC_RESET;
      carry_reg <= 1'b0;
      overflow_reg <= 1'b0;
      norm_done_reg <= 1'b0;
      mult_result_reg <= ACC_RESET;
      acc_zero_reg <= 1'b1;
      acc_neg_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      acc_zero_reg <= (acc_next == ACC_RESET); //RL2
      acc_neg_reg <= acc_next[MSB];
      carry_reg <= carry_next;
      overflow_reg <= overflow_next;
      norm_done_reg <= norm_done_next;
      mult_result_reg <= mult_result_next; //RL16
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mult_operand_reg <= OPERAND_RESET;
    end else if (operand_load_in) begin
      mult_operand_reg <= data_bus_in; //RL15
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      store_data_reg <= OPERAND_RESET;
      store_valid_reg <= 1'b0;
      bit_test_reg <= 1'b0;
    end else begin
      store_valid_reg <= store_in;
      if (store_in) begin
        store_data_reg <= store_half;
      end
      if (bit_test_in) begin
        bit_test_reg <= bit_sel_val; //RL2
      end
    end
  end

  assign acc_out = acc_reg;
  assign jump_target_out = acc_reg; //RL3
  assign store_data_out = store_data_reg;
  assign store_valid_out = store_valid_reg;
  assign mult_result_out = mult_result_reg;
  assign mult_operand_out = mult_operand_reg;
  // flags are registered from the next value so they line up with acc_out
  assign acc_zero_out = acc_zero_reg; //RL2
  assign acc_neg_out = acc_neg_reg;
  assign carry_out = carry_reg;
  assign overflow_out = overflow_reg;
  assign bit_test_out = bit_test_reg;
  assign norm_done_out = norm_done_reg;

  // assertions
  a_add_writeback: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (alu_op_in == OP_ADD) |=> (acc_reg == $past(sum[ACC_W-1:0]))) //RL7
    else $error("add result not written to accumulator");
  a_prod_capture: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (mult_en_in && !mult_signed_in) |=> (mult_result_reg == $past(mul_a) * $past(prog_bus_in))) //RL14
    else $error("unsigned product wrong");
  a_prod_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !mult_en_in |=> $stable(mult_result_reg)) //RL16
    else $error("product register changed without multiply");
  a_operand_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !operand_load_in |=> $stable(mult_operand_reg)) //RL15
    else $error("operand register changed without load");
  a_scale_low_zero: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (scale_amt != 0) |-> ((scale_out & ((32'h1 << scale_amt) - 32'h1)) == 32'h0)) //RL12
    else $error("scaled low bits not zero");
  a_scale_zero_ext: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (!sign_extend_enable_in && scale_amt == 0) |-> (scale_out[ACC_W-1:DATA_W] == 16'h0000)) //RL13
    else $error("high bits not zero filled");
  a_store_keeps_acc: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (store_in && alu_op_in == OP_NOP) |=> $stable(acc_reg) && store_valid_reg) //RL9
    else $error("store disturbed accumulator");
  a_pshift_r6: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (pshift_mode_in == PM_R6) |-> (prod_shifted[ACC_W-1:ACC_W-7] == {7{mult_result_reg[MSB]}})) //RL19
    else $error("right six shift not arithmetic");
  a_upper_store: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (store_in && store_upper_in && store_shift_in == 0) |=> (store_data_reg == $past(acc_reg[ACC_W-1:DATA_W]))) //RL8
    else $error("upper half store wrong");

  // independent signed product for checking the multiplier
  wire logic signed [ACC_W-1:0] prod_check;
  assign prod_check = $signed(mul_a) * $signed(prog_bus_in);

  sequence s_norm_shift;
    (alu_op_in == OP_NORM) && norm_needed;
  endsequence
  sequence s_norm_settled;
    (alu_op_in == OP_NORM) && !norm_needed;
  endsequence

  a_sub_writeback: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL7
    (alu_op_in == OP_SUB) |=> (acc_reg == $past(diff[ACC_W-1:0])))
    else $error("sub result not written to accumulator");
  a_norm_step: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL4
    s_norm_shift |=> (acc_reg == {$past(acc_reg[ACC_W-2:0]), 1'b0}))
    else $error("normalize step did not shift left");
  a_norm_finish: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL4
    s_norm_settled |=> (norm_done_reg && $stable(acc_reg)))
    else $error("normalize did not report done");
  a_jump_follows: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL3
    (alu_op_in == OP_LOAD) |=> (jump_target_out == $past(alu_b)))
    else $error("jump target not accumulator");
  a_bit_capture: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL5
    bit_test_in |=> (bit_test_reg == $past(data_bus_in[(DATA_W-1) - bit_sel_in])))
    else $error("bit test result wrong");
  a_bit_hold: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL5
    !bit_test_in |=> $stable(bit_test_reg))
    else $error("bit test result changed without test");
  a_store_pulse: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL8
    !store_in |=> !store_valid_reg)
    else $error("store valid without request");
  a_lower_store: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL8
    (store_in && !store_upper_in && store_shift_in == 0) |=> (store_data_reg == $past(acc_reg[DATA_W-1:0])))
    else $error("lower half store wrong");
  a_scale_sign_ext: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL13
    (sign_extend_enable_in && scale_amt == 0) |-> (scale_out[ACC_W-1:DATA_W] == {DATA_W{data_bus_in[DATA_W-1]}}))
    else $error("high bits not sign extended");
  a_scale_pass: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL10
    (scale_amt == 0) |-> (scale_out[DATA_W-1:0] == data_bus_in))
    else $error("unshifted word not passed through");
  a_and_single: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL1
    (alu_op_in == OP_AND) |=> (acc_reg == ($past(acc_reg) & $past(alu_b))))
    else $error("and result not in one cycle");
  a_zero_flag: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL2
    acc_zero_reg == (acc_reg == ACC_RESET))
    else $error("zero flag disagrees with accumulator");
  a_src_select: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL6
    (alu_src_prod_in && alu_op_in == OP_LOAD) |=> (acc_reg == $past(prod_shifted)))
    else $error("product path not selected");
  a_signed_prod: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL14
    (mult_en_in && mult_signed_in) |=> (mult_result_reg == $past(prod_check)))
    else $error("signed product wrong");
  a_operand_load: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL15
    operand_load_in |=> (mult_operand_reg == $past(data_bus_in)))
    else $error("operand register not loaded");
  a_mac_same_cycle: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL17
    (operand_load_in && mult_en_in && !mult_signed_in) |=> (mult_result_reg == $past(data_bus_in) * $past(prog_bus_in)))
    else $error("same cycle operands not multiplied");
  a_pshift_l4: assert property (@(posedge clock_in) disable iff (!rstn_in) //RL18
    (pshift_mode_in == PM_L4) |-> (prod_shifted == (mult_result_reg << PSHIFT_L4)))
    else $error("left four product shift wrong");
endmodule

// ===== design/mac_pkg.sv
// constants, opcodes and shift modes for the fixed-point multiply-accumulate datapath
// assumes a single clock domain shared with the instruction sequencer
package mac_pkg;
  localparam int DATA_W = 16;
  localparam int ACC_W = 32;
  localparam int SHIFT_W = 5;
  localparam int BIT_SEL_W = 4;
  localparam logic [SHIFT_W-1:0] SCALE_MAX = 5'h10;
  localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] OPERAND_RESET = 16'h0000;
  // product shift mode amounts, store shift width and accumulator bit indices
  localparam int PSHIFT_L1 = 1;
  localparam int PSHIFT_L4 = 4;
  localparam int PSHIFT_R6 = 6;
  localparam int OUT_SHIFT_W = 3;
  localparam int MSB = ACC_W - 1;
  localparam int NORM_TOP = ACC_W - 2;

  typedef enum logic [3:0] {
    OP_NOP  = 4'h0,
    OP_ADD  = 4'h1,
    OP_SUB  = 4'h2,
    OP_LOAD = 4'h3,
    OP_AND  = 4'h4,
    OP_OR   = 4'h5,
    OP_XOR  = 4'h6,
    OP_NORM = 4'h7,
    OP_ZERO = 4'h8,
    OP_NEG  = 4'h9
  } alu_op_t;

  typedef enum logic [1:0] {
    PM_NONE = 2'h0,
    PM_L1   = 2'h1,
    PM_L4   = 2'h2,
    PM_R6   = 2'h3
  } pshift_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_NORM  = 3'b100
  } norm_state_t;
endpackage

// ===== test/bus_source_model.sv
// sequencer-side bus source: drives data and program bus words for one cycle
// assumes the bench raises valid_in just after a clock edge and holds it one cycle
`timescale 1ns/1ps
module bus_source_model
  import mac_pkg::*;
(
  // clock
  input wire logic clock_in,
  // words from the bench
  input wire logic valid_in,
  input wire logic [DATA_W-1:0] data_word_in,
  input wire logic [DATA_W-1:0] prog_word_in,
  // bus lines
  output logic [DATA_W-1:0] data_bus_out,
  output logic [DATA_W-1:0] prog_bus_out
);
  logic [DATA_W-1:0] last_data_reg = 16'h0000;
  logic [DATA_W-1:0] last_prog_reg = 16'h0000;
  always_ff @(posedge clock_in) begin
    if (valid_in) begin
      last_data_reg <= data_word_in;
      last_prog_reg <= prog_word_in;
    end
  end
  // released buses show the inverse of the last word, so a stale capture never matches
  assign data_bus_out = valid_in ? data_word_in : ~last_data_reg;
  assign prog_bus_out = valid_in ? prog_word_in : ~last_prog_reg;
endmodule

// ===== test/fixed_point_mac_datapath_tb.sv
// self-checking bench for the multiply-accumulate datapath
// assumes one 100 MHz clock and inputs changed 1 ns after each rising edge
`timescale 1ns/1ps
module fixed_point_mac_datapath_tb;
  import mac_pkg::*;
  logic clock_in, rstn_in, src, sign_extend_enable, ld, men, msn, dv, st, stu, bt;
  logic [3:0] op, bsel;
  logic [SHIFT_W-1:0] sh;
  logic [1:0] pm;
  logic [OUT_SHIFT_W-1:0] ssh;
  logic [DATA_W-1:0] dw, pw, dbus, pbus, sdat, mop;
  logic [ACC_W-1:0] acc, jt, mres;
  logic az, an, cy, ov, btr, nd, sv;
  logic [ACC_W-1:0] pexp [4];
  int failures = 0;
  int cmp_count = 0;

  bus_source_model bus_source_model_inst (.clock_in(clock_in), .valid_in(dv), .data_word_in(dw),
    .prog_word_in(pw), .data_bus_out(dbus), .prog_bus_out(pbus));
  fixed_point_mac_datapath fixed_point_mac_datapath_inst (.clock_in(clock_in), .rstn_in(rstn_in),
    .alu_op_in(op), .alu_src_prod_in(src), .scale_shift_in(sh), .sign_extend_enable_in(sign_extend_enable),
    .pshift_mode_in(pm), .operand_load_in(ld), .mult_en_in(men), .mult_signed_in(msn),
    .data_bus_in(dbus), .prog_bus_in(pbus), .store_in(st), .store_upper_in(stu), .store_shift_in(ssh),
    .bit_test_in(bt), .bit_sel_in(bsel), .acc_out(acc), .jump_target_out(jt), .store_data_out(sdat),
    .store_valid_out(sv), .mult_result_out(mres), .mult_operand_out(mop), .acc_zero_out(az),
    .acc_neg_out(an), .carry_out(cy), .overflow_out(ov), .bit_test_out(btr), .norm_done_out(nd));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc;
    @(posedge clock_in);
    #1;
  endtask
  task automatic idle;
    op = OP_NOP; src = 0; sh = 0; sign_extend_enable = 0; pm = PM_NONE; ld = 0; men = 0; msn = 0;
    dv = 0; st = 0; stu = 0; ssh = 0; bt = 0; bsel = 0; dw = 16'h0000; pw = 16'h0000;
  endtask
  task automatic alu(input logic [3:0] o, input logic [15:0] d, input logic [4:0] s, input logic x);
    op = o; dw = d; sh = s; sign_extend_enable = x; dv = 1; cyc; idle;
  endtask

  task automatic t_scale;
    alu(OP_LOAD, 16'h0000, 5'h00, 1'b0);
    alu(OP_ADD, 16'h0005, 5'h04, 1'b0); chk(acc, 32'h0000_0050);
    alu(OP_LOAD, 16'h8001, 5'h04, 1'b1); chk(acc, 32'hfff8_0010);
    chk({31'h0, an}, 32'h1);
    alu(OP_LOAD, 16'h8001, 5'h04, 1'b0); chk(acc, 32'h0008_0010);
    alu(OP_LOAD, 16'h0005, 5'h1f, 1'b0); chk(acc, 32'h0005_0000);
    alu(OP_ZERO, 16'h0000, 5'h00, 1'b0); chk({31'h0, az}, 32'h1);
  endtask

  task automatic t_arith;
    alu(OP_LOAD, 16'h7fff, 5'h10, 1'b0);
    alu(OP_ADD, 16'h7fff, 5'h10, 1'b0); chk(acc, 32'hfffe_0000);
    chk({30'h0, cy, ov}, 32'h1);
    alu(OP_SUB, 16'h0001, 5'h00, 1'b0); chk(acc, 32'hfffd_ffff);
    chk({30'h0, cy, ov}, 32'h2);
    alu(OP_AND, 16'h00ff, 5'h10, 1'b0); chk(acc, 32'h00fd_0000);
    alu(OP_XOR, 16'h0001, 5'h10, 1'b0); chk(acc, 32'h00fc_0000);
    alu(OP_NEG, 16'h0000, 5'h00, 1'b0); chk(acc, 32'hff04_0000);
    chk({30'h0, an, ov}, 32'h2);
    alu(OP_LOAD, 16'h8000, 5'h10, 1'b0);
    alu(OP_NEG, 16'h0000, 5'h00, 1'b0); chk({30'h0, an, ov}, 32'h3);
  endtask

  task automatic t_reset;
    alu(OP_LOAD, 16'h1234, 5'h00, 1'b0);
    rstn_in = 0; cyc;
    chk(acc, 32'h0); chk({31'h0, az}, 32'h1); chk(mres, 32'h0);
    rstn_in = 1;
    alu(OP_LOAD, 16'h0042, 5'h00, 1'b0); chk(acc, 32'h0000_0042);
  endtask

  task automatic t_mult;
    ld = 1; men = 1; dw = 16'h0003; pw = 16'h0004; dv = 1; cyc; idle;
    chk(mres, 32'h0000_000c); chk({16'h0, mop}, 32'h3);
    men = 1; msn = 1; dw = 16'h1234; pw = 16'hfffe; dv = 1; cyc; idle;
    chk(mres, 32'hffff_fffa); chk({16'h0, mop}, 32'h3);
    men = 1; pw = 16'hfffe; dv = 1; cyc; idle; chk(mres, 32'h0002_fffa);
    ld = 1; men = 1; msn = 1; dw = 16'hfff0; pw = 16'h0010; dv = 1; cyc; idle;
    pexp = '{32'hffff_ff00, 32'hffff_fe00, 32'hffff_f000, 32'hffff_fffc};
    for (int m = 0; m < 4; m++) begin
      op = OP_LOAD; src = 1; pm = m[1:0]; cyc; idle;
      chk(acc, pexp[m]);
    end
    chk(mres, 32'hffff_ff00);
  endtask

  task automatic t_store;
    alu(OP_LOAD, 16'h1234, 5'h10, 1'b0);
    alu(OP_OR, 16'h8765, 5'h00, 1'b0);
    st = 1; cyc; idle; chk({15'h0, sv, sdat}, 32'h1_8765);
    st = 1; stu = 1; ssh = 3'h4; cyc; idle; chk({15'h0, sv, sdat}, 32'h1_2348);
    chk(acc, 32'h1234_8765);
    cyc; chk({31'h0, sv}, 32'h0);
  endtask

  task automatic t_bit;
    bt = 1; dw = 16'h8000; dv = 1; cyc; idle; chk({31'h0, btr}, 32'h1);
    bt = 1; bsel = 4'h1; dw = 16'h8000; dv = 1; cyc; idle; chk({31'h0, btr}, 32'h0);
    bt = 1; bsel = 4'hf; dw = 16'h0001; dv = 1; cyc; idle; chk({31'h0, btr}, 32'h1);
  endtask

  task automatic t_norm;
    alu(OP_LOAD, 16'h0001, 5'h00, 1'b0);
    alu(OP_NORM, 16'h0000, 5'h00, 1'b0); chk(acc, 32'h2); chk({31'h0, nd}, 32'h0);
    alu(OP_LOAD, 16'h4000, 5'h10, 1'b0);
    alu(OP_NORM, 16'h0000, 5'h00, 1'b0); chk(acc, 32'h4000_0000); chk({31'h0, nd}, 32'h1);
    chk(jt, 32'h4000_0000);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    rstn_in = 0;
    idle;
    repeat (12) @(posedge clock_in);
    chk(acc, 32'h0);
    chk({31'h0, az}, 32'h1);
    #1;
    rstn_in = 1;
    t_scale;
    t_arith;
    t_mult;
    t_store;
    t_bit;
    t_norm;
    t_reset;
    wrap_up;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule
